// File: shared/asrc_pkg.sv
// Shared constants and types for the converter serial readout block
package asrc_pkg;

  // ---------------------------------------------------------------
  // Result format
  // ---------------------------------------------------------------
  localparam int RES_W = 16;
  localparam int IN_W  = 18;
  localparam logic signed [IN_W-1:0] CODE_MAX = 18'sh07fff;
  localparam logic signed [IN_W-1:0] CODE_MIN = -18'sh08000;
  localparam int CHAIN_DEPTH = 16;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int APERTURE_NS    = 20;
  localparam int CONV_NS        = 1000;
  localparam int CONV_MIN_NS    = 500;
  localparam int CONV_MAX_NS    = 1600;
  localparam int APERTURE_CYC   = (APERTURE_NS * CLK_MHZ) / 1000;
  localparam int CONV_CYC       = (CONV_NS * CLK_MHZ) / 1000;
  localparam int CNT_W          = 8;

  // ---------------------------------------------------------------
  // Serial clock step counter width (gray coded across domains)
  // ---------------------------------------------------------------
  localparam int STEP_W = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ASRC_IDLE     = 2'b00,
    ASRC_APERTURE = 2'b01,
    ASRC_CONVERT  = 2'b10
  } asrc_state_t;

  typedef enum logic {
    ASRC_MODE_CHAIN  = 1'b0,
    ASRC_MODE_SELECT = 1'b1
  } asrc_mode_t;

  typedef struct packed {
    logic dat;
    logic oe;
  } asrc_pin_out_t;

endpackage

// File: hdl/asrc_top.sv
// Converter control: conversion timing, mode latch and serial result readout
`timescale 1ns/10ps
`default_nettype none
module asrc_top
  import asrc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_sck,
  input  wire logic                   i_convert_start,
  input  wire logic                   i_serial_in,
  input  wire logic signed [IN_W-1:0] i_analog,
  output var asrc_pin_out_t           o_serial_out,
  output logic                        o_busy
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Step count crosses in gray code: only one bit moves per serial
  // clock, so a capture mid-change is off by at most one step
  function automatic logic [STEP_W-1:0] bin2gray(input logic [STEP_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // Top bit passes straight; each lower bit folds in the one above
  function automatic logic [STEP_W-1:0] gray2bin(input logic [STEP_W-1:0] g);
    logic [STEP_W-1:0] b;
    b = '0;
    b[STEP_W-1] = g[STEP_W-1];
    for (int i = STEP_W - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // Serial clock domain: step counter and serial_in capture
  // ---------------------------------------------------------------
  logic [STEP_W-1:0] sck_cnt;
  logic [STEP_W-1:0] sck_gray;
  logic [1:0]        sdi_hist;

  // Only counting and serial_in capture live here, so a stopped clock loses nothing.
  // Two history slots suffice: a slot is rewritten two serial clocks
  // after its capture, long after the core has read it, provided the
  // serial clock period stays above five core clocks.
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      sck_cnt  <= '0;
      sck_gray <= '0;
      sdi_hist <= '0;
    end else begin
      sdi_hist[sck_cnt[0]] <= i_serial_in;
      sck_cnt  <= sck_cnt + 1'b1;
      sck_gray <= bin2gray(sck_cnt + 1'b1);
    end
  end

  // ---------------------------------------------------------------
  // Core domain: synchronisers
  // ---------------------------------------------------------------
  logic [STEP_W-1:0] gray_s1;
  logic [STEP_W-1:0] gray_s2;
  logic [1:0]        cnv_sync;
  logic [1:0]        sdi_sync;
  logic              cnv_prev;

  // Pins and the gray count pass two flops each; only the second
  // flop of each pair feeds any logic. The pin edge detector resets
  // low, the idle level of convert_start, so reset makes no false edge.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gray_s1  <= '0;
      gray_s2  <= '0;
      cnv_sync <= '0;
      sdi_sync <= '0;
      cnv_prev <= 1'b0;
    end else begin
      gray_s1  <= sck_gray;
      gray_s2  <= gray_s1;
      cnv_sync <= {cnv_sync[0], i_convert_start};
      sdi_sync <= {sdi_sync[0], i_serial_in};
      cnv_prev <= cnv_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  // One pending serial step is taken per core clock; seen_cnt trails
  // the synchronised count and catches up one step at a time
  logic [STEP_W-1:0] seen_cnt;
  wire  logic        cnv_lvl   = cnv_sync[1];
  wire  logic        sdi_lvl   = sdi_sync[1];
  wire  logic        cnv_rise  = cnv_lvl & ~cnv_prev;
  wire  logic [STEP_W-1:0] step_cnt = gray2bin(gray_s2);
  wire  logic        step      = (step_cnt != seen_cnt);
  wire  logic [STEP_W-1:0] seen_next = seen_cnt + 1'b1;
  // Entry written together with the counter value now seen
  wire  logic        step_bit  = sdi_hist[seen_cnt[0]];
  // Out-of-range inputs clamp to the two end codes of the result
  wire  logic        clamp_hi  = (i_analog > CODE_MAX);
  wire  logic        clamp_lo  = (i_analog < CODE_MIN);
  wire  logic [RES_W-1:0] clamped = clamp_hi ? CODE_MAX[RES_W-1:0] :
                                    clamp_lo ? CODE_MIN[RES_W-1:0] :
                                    i_analog[RES_W-1:0];

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  asrc_state_t      state;
  asrc_mode_t       mode;
  logic [CNT_W-1:0] timer;
  logic [RES_W-1:0] sample;

  // Either pin low acts as the output enable in select mode
  wire logic sel_mode = (mode == ASRC_MODE_SELECT);
  wire logic en_low   = ~cnv_lvl | ~sdi_lvl;
  wire logic conv_end = (state == ASRC_CONVERT) && (timer == CNT_W'(CONV_CYCLES - 1));

  // Edges during a conversion are ignored; hosts must keep spacing.
  // Timeline from the detected edge: aperture for APERTURE_CYC clocks,
  // then conversion until CONV_CYCLES clocks in total have passed, so
  // CONV_CYCLES alone sets the edge-to-result time.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state  <= ASRC_IDLE;
      mode   <= ASRC_MODE_SELECT;
      timer  <= '0;
      sample <= '0;
    end else begin
      unique case (state)
        ASRC_IDLE: begin
          if (cnv_rise) begin
            state <= ASRC_APERTURE;
            mode  <= sdi_lvl ? ASRC_MODE_SELECT : ASRC_MODE_CHAIN;
            timer <= '0;
          end
        end
        ASRC_APERTURE: begin
          timer <= timer + 1'b1;
          if (timer == CNT_W'(APERTURE_CYC - 1)) begin
            sample <= clamped;
            state  <= ASRC_CONVERT;
            timer  <= CNT_W'(APERTURE_CYC);
          end
        end
        ASRC_CONVERT: begin
          // Internal clock only, serial clock plays no part
          timer <= timer + 1'b1;
          if (conv_end) begin
            state <= ASRC_IDLE;
          end
        end
        // Unused code: fall back to idle rather than hang
        default: begin
          state <= ASRC_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output shifter
  // ---------------------------------------------------------------
  logic [RES_W-1:0] shreg;
  logic             hold;
  logic             dat;

  // Bit taken in per step: chain input, or zeros in select mode.
  // Chain data enters at the bottom and leaves at the top, which gives
  // the sixteen-step delay from serial_in to serial_out.
  wire logic fill_bit = sel_mode ? 1'b0 : step_bit;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shreg      <= '0;
      hold       <= 1'b0;
      dat        <= 1'b0;
      seen_cnt   <= '0;
    end else begin
      if (step) begin
        seen_cnt <= seen_next;
      end
      // Conversion end wins over a step in the same clock
      if (conv_end) begin
        shreg      <= sample;
        // A held enable at conversion end turns on the busy indication
        hold       <= sel_mode & en_low;
        // Busy end shows as a high bit; else MSB first
        dat        <= (sel_mode & en_low) ? 1'b1 : sample[RES_W-1];
      end else if (state != ASRC_IDLE) begin
        dat <= 1'b0;                                        // Busy low while converting
      end else if (step) begin
        // Updates only follow a serial clock step
        if (hold) begin
          hold <= 1'b0;
          dat  <= shreg[RES_W-1];
        end else begin
          shreg <= {shreg[RES_W-2:0], fill_bit};
          dat   <= shreg[RES_W-2];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // Chain mode always drives; select mode only on an active enable.
  // The enable follows the synchronised pins, so it lags a pin change
  // by one to two core clocks; hosts allow for that before sampling.
  wire logic oe_drive = sel_mode ? en_low : 1'b1;

  // Both fields leave in one carrier so the pin pair changes together
  assign o_serial_out = '{dat: dat, oe: oe_drive};
  // Status only: high from the detected edge to the result
  assign o_busy       = (state != ASRC_IDLE);

endmodule
`default_nettype wire

// File: verif/asrc_checker.sv
// Assertion checker for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module asrc_checker
  import asrc_pkg::*;
#(parameter int CONV_CYCLES = CONV_CYC) (
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  input wire logic                   i_sck,
  input wire logic                   i_convert_start,
  input wire logic                   i_serial_in,
  input wire logic signed [IN_W-1:0] i_analog,
  input wire asrc_pin_out_t          o_serial_out,
  input wire logic                   o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  localparam int LEN = CONV_CYCLES; // Edge-to-result span, aperture included
  logic [CNT_W-1:0] bcnt;
  logic [5:0]       sck_h;
  logic             sck_q;
  logic             sel;
  // Busy length, recent clock steps, mode seen at busy start
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bcnt  <= '0;
      sck_h <= '0;
      sck_q <= 1'b0;
      sel   <= 1'b1;
    end else begin
      bcnt  <= o_busy ? bcnt + 1'b1 : '0;
      sck_h <= {sck_h[4:0], i_sck & ~sck_q};
      sck_q <= i_sck;
      sel   <= $rose(o_busy) ? i_serial_in : sel;
    end
  end
  property p_start; $rose(i_convert_start) && !o_busy |-> ##[1:4] o_busy; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_len; $fell(o_busy) |-> bcnt >= LEN - 1 && bcnt <= LEN + 1; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_oe_cnv; !i_convert_start [*4] |-> o_serial_out.oe; endproperty
  a_oe_cnv: assert property (p_oe_cnv) else $error("no drive");
  property p_oe_sdi; !i_serial_in [*4] |-> o_serial_out.oe; endproperty
  a_oe_sdi: assert property (p_oe_sdi) else $error("no drive");
  property p_hiz; (i_convert_start && i_serial_in && sel && !o_busy) [*4] |-> !o_serial_out.oe; endproperty
  a_hiz: assert property (p_hiz) else $error("not released");
  property p_chain; !sel && !o_busy |-> o_serial_out.oe; endproperty
  a_chain: assert property (p_chain) else $error("chain off");
  property p_step; $changed(o_serial_out.dat) |-> (|sck_h) || o_busy || $past(o_busy); endproperty
  a_step: assert property (p_step) else $error("stray change");
  property p_first;
    $fell(o_busy) |-> o_serial_out.dat == ((sel && !(i_serial_in && i_convert_start)) ? 1'b1 : i_analog[IN_W-1]);
  endproperty
  a_first: assert property (p_first) else $error("bad first bit");
endmodule
`default_nettype wire

// File: verif/asrc_host.sv
// Host model: convert start, serial clock, result capture
`timescale 1ns/10ps
`default_nettype none
module asrc_host
  import asrc_pkg::*;
(
  input  wire logic          i_clk,
  input  wire asrc_pin_out_t i_serial_out,
  output logic               o_sck,
  output logic               o_convert_start,
  output logic               o_serial_in
);
  logic last;
  // Released line shows no stale value
  wire logic line = i_serial_out.oe ? i_serial_out.dat : ~last;
  initial begin
    o_sck = 1'b0;
    o_convert_start = 1'b0;
    o_serial_in = 1'b1;
    last = 1'b0;
  end
  task pins(input logic c, input logic s);
    @(posedge i_clk);
    #1 o_convert_start = c;
    o_serial_in = s;
  endtask
  // Mode level set up before the rise, no clock during conversion
  task conv(input logic s);
    pins(1'b0, s);
    repeat (3) @(posedge i_clk);
    pins(1'b1, s);
    #1700;
  endtask
  // Sample just before each rise; clock stands still between frames
  task rd(input int n, output logic [31:0] w, input logic [15:0] pat);
    w = '0;
    for (int i = 0; i < n; i++) begin
      o_serial_in = pat[15 - (i % 16)];
      #32 w = {w[30:0], line};
      last = line;
      o_sck = 1'b1;
      #32 o_sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: verif/test_asrc_top.sv
// Self-checking bench for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module test_asrc_top
  import asrc_pkg::*;
;
  logic                   clk, rst, sck, convert_start, serial_in, busy;
  logic signed [IN_W-1:0] ana;
  asrc_pin_out_t          sout;
  logic [31:0]            w;
  int                     n_fail = 0;
  int                     num_checks = 0;
  asrc_top #(.CONV_CYCLES(CONV_CYC)) dut_u (.i_clk(clk), .i_rst(rst), .i_sck(sck), .i_convert_start(convert_start),
    .i_serial_in(serial_in), .i_analog(ana), .o_serial_out(sout), .o_busy(busy));
  asrc_host host_u (.i_clk(clk), .i_serial_out(sout), .o_sck(sck), .o_convert_start(convert_start), .o_serial_in(serial_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Boundary and clamped codes, one conversion each
  task automatic t_select();
    logic signed [IN_W-1:0] a [6] = '{18'sh00000, 18'sh07fff, 18'sh3ffff, 18'sh38000, 18'sh0abcd, 18'sh20000};
    logic [15:0] e [6] = '{16'h0000, 16'h7fff, 16'hffff, 16'h8000, 16'h7fff, 16'h8000};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) #1 ana = a[i];
      host_u.conv(1'b1);
      chk(32'(sout.oe), 32'h0);
      chk(32'(busy), 32'h0);
      host_u.pins(1'b0, 1'b1);
      repeat (4) @(posedge clk);
      #1 chk(32'(sout.oe), 32'h1);
      host_u.rd(16, w, 16'hffff);
      chk(w, 32'(e[i]));
    end
    $display("select test done");
  endtask
  // Busy bit armed by a low enable; a rise mid conversion is ignored
  task t_busy();
    @(posedge clk) #1 ana = 18'sh3edcb;
    host_u.pins(1'b0, 1'b1);
    host_u.pins(1'b1, 1'b1);
    #300 ana = 18'sh00000;
    chk(32'(busy), 32'h1);
    host_u.pins(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    host_u.pins(1'b1, 1'b0);
    #1700 host_u.rd(17, w, 16'h0000);
    chk(w, 32'h0001edcb);
    $display("busy test done");
  endtask
  // Result, then the shifted-in pattern 16 clocks later
  task t_chain();
    @(posedge clk) #1 ana = 18'sh05a5c;
    host_u.conv(1'b0);
    host_u.rd(32, w, 16'h3c96);
    chk(w, 32'h5a5c3c96);
    $display("chain test done");
  endtask
  initial begin
    rst = 1'b1;
    ana = '0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_select();
    t_busy();
    t_chain();
    finish_test();
  end
  // Whole run is about 24 us
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule
bind asrc_top asrc_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.i_clk, .i_rst, .i_sck, .i_convert_start,
  .i_serial_in, .i_analog, .o_serial_out, .o_busy);
`default_nettype wire
